// File: design/gauge_status_control_regs.sv
// Status and control registers of a battery charge gauge, with charge counter and conversion sequencer.
// Assumes a serial-bus front end on i_lclk that issues one register operation at a time,
// and a measurement section on i_mclk that reports conversion results and integrator steps.
`include "gauge_consts.svh"
module gauge_status_control_regs #(
  parameter int ACR_WIDTH        = 16,
  parameter int SCAN_WAIT_CYCLES = `GAUGE_SCAN_CYCLES
) (
  // Core clock and synchronous reset.
  input  wire logic                 i_mclk,
  input  wire logic                 i_srst,
  // Serial-side request port, clocked by the bus.
  input  wire logic                 i_lclk,
  input  wire logic                 i_lnk_read,
  input  wire logic                 i_lnk_write,
  input  wire logic                 i_lnk_alert_ack,
  input  wire logic                 i_lnk_sel,
  input  wire logic [7:0]           i_lnk_wdata,
  output logic                      o_lnk_busy,
  output logic                      o_lnk_done,
  output logic [7:0]                o_lnk_rdata,
  // Conversion results from the measurement section.
  input  wire logic                 i_conv_done,
  input  wire logic [15:0]          i_conv_result,
  input  wire logic [15:0]          i_conv_hi_limit,
  input  wire logic [15:0]          i_conv_lo_limit,
  output logic                      o_conv_start,
  output logic [1:0]                o_conv_kind,
  // Integrator steps and charge limits.
  input  wire logic                 i_int_up,
  input  wire logic                 i_int_down,
  input  wire logic [ACR_WIDTH-1:0] i_chg_hi_limit,
  input  wire logic [ACR_WIDTH-1:0] i_chg_lo_limit,
  output logic [ACR_WIDTH-1:0]      o_accumulated_charge_count,
  // Supply monitor and analog power.
  input  wire logic                 i_supply_low,
  output logic                      o_analog_on,
  // Multifunction open-drain pin.
  input  wire logic                 i_alert_charge_done_pin,
  output logic                      o_alert_charge_done_pin,
  output logic                      o_alert_charge_done_pin_oe
);
  // ---------------- Link domain ----------------
  logic       lrst;
  logic       ack_sync;
  logic       req_tog;
  logic [1:0] lnk_op;
  logic       lnk_sel;
  logic [7:0] lnk_wdata;
  logic       ack_tog;
  logic [7:0] core_rdata;

  // Reset and the acknowledge toggle enter the link domain.
  gauge_sync2 #(.WIDTH(2)) u_lnk_sync (
    .i_clk (i_lclk),
    .i_d   ({i_srst, ack_tog}),
    .o_q   ({lrst, ack_sync})
  );

  wire       lnk_any = i_lnk_read | i_lnk_write | i_lnk_alert_ack;
  wire [1:0] lnk_new_op = i_lnk_alert_ack ? `GAUGE_OP_ALERT_ACK :
                          (i_lnk_write ? `GAUGE_OP_WRITE : `GAUGE_OP_READ);
  wire       lnk_ack_seen = o_lnk_busy && (ack_sync == req_tog);

  // Capture one request, hold it stable and flip the request toggle until the core answers.
  always_ff @(posedge i_lclk)
  begin
    if (lrst)
    begin
      req_tog     <= 1'b0;
      lnk_op      <= `GAUGE_OP_READ;
      lnk_sel     <= `GAUGE_SEL_STATUS;
      lnk_wdata   <= 8'h00;
      o_lnk_busy  <= 1'b0;
      o_lnk_done  <= 1'b0;
      o_lnk_rdata <= 8'h00;
    end
    else
    begin
      o_lnk_done <= lnk_ack_seen;
      if (!o_lnk_busy && lnk_any)
      begin
        req_tog    <= ~req_tog;
        lnk_op     <= lnk_new_op;
        lnk_sel    <= i_lnk_sel;
        lnk_wdata  <= i_lnk_wdata;
        o_lnk_busy <= 1'b1;
      end
      else if (lnk_ack_seen)
      begin
        o_lnk_busy  <= 1'b0;
        o_lnk_rdata <= core_rdata; // Stable: written with the acknowledge toggle.
      end
    end
  end

  // ---------------- Core domain ----------------
  logic                   req_sync;
  logic                   drop_sync;
  logic                   pin_sync;
  logic                   req_prev;
  gauge_pkg::reg_byte_t   alert_flags;
  gauge_pkg::reg_byte_t   operation_control;
  gauge_pkg::seq_state_e  seq;
  logic [1:0]             run_mode;
  logic [31:0]            pause_cnt;
  logic [12:0]            pre_cnt;
  logic [ACR_WIDTH-1:0]   accumulated_charge_count;

  // Request toggle, supply monitor and pin level enter the core domain.
  gauge_sync2 #(.WIDTH(3)) u_core_sync (
    .i_clk (i_mclk),
    .i_d   ({req_tog, i_supply_low, i_alert_charge_done_pin}),
    .o_q   ({req_sync, drop_sync, pin_sync})
  );

  // Request decode; op, select and data are held stable by the link side.
  wire req_seen   = req_sync ^ req_prev;
  wire rd_status  = req_seen && (lnk_op == `GAUGE_OP_READ) && (lnk_sel == `GAUGE_SEL_STATUS);
  wire rd_any     = req_seen && (lnk_op == `GAUGE_OP_READ);
  wire wr_control = req_seen && (lnk_op == `GAUGE_OP_WRITE) && (lnk_sel == `GAUGE_SEL_CONTROL);
  wire alert_ack  = req_seen && (lnk_op == `GAUGE_OP_ALERT_ACK);

  // Control fields.
  wire [1:0] mode     = operation_control[`GAUGE_CT_MODE_MSB:`GAUGE_CT_MODE_LSB];
  wire [2:0] pre_code = operation_control[`GAUGE_CT_PRE_MSB:`GAUGE_CT_PRE_LSB];
  wire [1:0] pin_fn   = operation_control[`GAUGE_CT_PIN_MSB:`GAUGE_CT_PIN_LSB];
  wire       shdn     = operation_control[`GAUGE_CT_SHDN];

  // Measurement runs only when powered up and the supply is good.
  wire measure_on = !shdn && !drop_sync;

  // Conversion limit check against the kind that is running.
  wire conv_evt = i_conv_done && measure_on &&
                  ((seq == gauge_pkg::SEQ_VOLT) || (seq == gauge_pkg::SEQ_CURR) || (seq == gauge_pkg::SEQ_TEMP));
  wire conv_hit = conv_evt && ((i_conv_result > i_conv_hi_limit) || (i_conv_result < i_conv_lo_limit));
  wire set_volt = conv_hit && (seq == gauge_pkg::SEQ_VOLT);
  wire set_curr = conv_hit && (seq == gauge_pkg::SEQ_CURR);
  wire set_temp = conv_hit && (seq == gauge_pkg::SEQ_TEMP);

  // Prescaler divisor: four to the code, with the top codes capped.
  wire [3:0]  pre_shift = (pre_code >= `GAUGE_PRE_CAP_CODE) ? `GAUGE_PRE_CAP_SHIFT : {pre_code, 1'b0};
  wire [13:0] pre_m     = 14'h0001 << pre_shift;
  wire [12:0] pre_top   = 13'(pre_m - 14'h0001);

  // Integrator ticks step the prescaler; a full prescaler count steps the charge count.
  wire tick_up   = measure_on && i_int_up && !i_int_down;
  wire tick_down = measure_on && i_int_down && !i_int_up;
  wire step_up   = tick_up && (pre_cnt >= pre_top);
  wire step_down = tick_down && (pre_cnt == 13'h0000);
  wire charge_full = (pin_fn == `GAUGE_PIN_CHG_DONE) && !pin_sync;

  wire [ACR_WIDTH-1:0] acr_inc = accumulated_charge_count + ACR_WIDTH'(1);
  wire [ACR_WIDTH-1:0] acr_dec = accumulated_charge_count - ACR_WIDTH'(1);
  wire [ACR_WIDTH-1:0] next_acr = charge_full ? {ACR_WIDTH{1'b1}} :
                                  (step_up ? acr_inc : (step_down ? acr_dec : accumulated_charge_count));
  wire set_wrap  = !charge_full && ((step_up && (accumulated_charge_count == {ACR_WIDTH{1'b1}})) ||
                                    (step_down && (accumulated_charge_count == '0)));
  wire tick_any  = tick_up || tick_down;
  wire set_chghi = tick_any && (next_acr > i_chg_hi_limit);
  wire set_chglo = tick_any && (next_acr < i_chg_lo_limit);
  wire set_drop  = drop_sync;

  wire [12:0] next_pre = shdn ? 13'h0000 :
                         (tick_up ? (step_up ? 13'h0000 : pre_cnt + 13'h0001) :
                         (tick_down ? (step_down ? pre_top : pre_cnt - 13'h0001) : pre_cnt));

  // Status update: a read clears, new events are ORed in afterwards so they win.
  wire [7:0] set_vec = {1'b0, set_curr, set_wrap, set_temp, set_chghi, set_chglo, set_volt, set_drop};
  wire [7:0] kept    = rd_status ? 8'h00 : alert_flags;
  wire [7:0] next_alert_flags = (kept | set_vec) & ~(8'h01 << `GAUGE_ST_RSVD);

  // Alert pin: held low from any limit or wrap event in alert mode until acknowledged.
  wire alert_evt = (pin_fn == `GAUGE_PIN_ALERT) && (|set_vec[`GAUGE_ST_CURR:`GAUGE_ST_VOLT]);
  wire next_alert_hold = alert_evt || (o_alert_charge_done_pin_oe && !alert_ack);

  // Sequencer decisions.
  wire seq_end    = conv_evt && (seq == gauge_pkg::SEQ_TEMP);
  wire single_end = seq_end && (run_mode == `GAUGE_MODE_SINGLE) && (mode == `GAUGE_MODE_SINGLE);
  wire seq_launch = (seq == gauge_pkg::SEQ_IDLE) && measure_on && (mode != `GAUGE_MODE_SLEEP);

  // Control register: host writes win over the sequencer returning single mode to sleep.
  wire [7:0] next_control = wr_control ? i_lnk_wdata_hold(lnk_wdata) :
                            (single_end ? {`GAUGE_MODE_SLEEP, operation_control[5:0]} : operation_control);

  function automatic logic [7:0] i_lnk_wdata_hold(input logic [7:0] d);
    i_lnk_wdata_hold = d;
  endfunction : i_lnk_wdata_hold

  // Request bookkeeping, answers and register updates.
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      req_prev          <= 1'b0;
      ack_tog           <= 1'b0;
      core_rdata        <= 8'h00;
      alert_flags       <= `GAUGE_STATUS_RST;
      operation_control <= `GAUGE_CONTROL_RST;
    end
    else
    begin
      req_prev          <= req_sync;
      alert_flags       <= next_alert_flags;
      operation_control <= next_control;
      if (req_seen)
      begin
        ack_tog <= ~ack_tog;
      end
      if (rd_any)
      begin
        core_rdata <= (lnk_sel == `GAUGE_SEL_STATUS) ? alert_flags : operation_control;
      end
    end
  end

  // Charge counter, prescaler and pin drivers.
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      accumulated_charge_count                        <= '0;
      pre_cnt                    <= 13'h0000;
      o_accumulated_charge_count <= '0;
      o_analog_on                <= 1'b0;
      o_alert_charge_done_pin    <= 1'b0;
      o_alert_charge_done_pin_oe <= 1'b0;
    end
    else
    begin
      accumulated_charge_count                        <= next_acr;
      pre_cnt                    <= next_pre;
      o_accumulated_charge_count <= next_acr;
      o_analog_on                <= !shdn;
      o_alert_charge_done_pin    <= 1'b0;
      o_alert_charge_done_pin_oe <= next_alert_hold;
    end
  end

  // Conversion sequencer: voltage, current, temperature, then per the mode latched at launch.
  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      seq          <= gauge_pkg::SEQ_IDLE;
      run_mode     <= `GAUGE_MODE_SLEEP;
      pause_cnt    <= 32'h0000_0000;
      o_conv_start <= 1'b0;
      o_conv_kind  <= `GAUGE_KIND_VOLT;
    end
    else
    begin
      o_conv_start <= 1'b0;
      case (seq)
        gauge_pkg::SEQ_IDLE:
        begin
          if (seq_launch)
          begin
            seq          <= gauge_pkg::SEQ_VOLT;
            run_mode     <= mode;
            o_conv_start <= 1'b1;
            o_conv_kind  <= `GAUGE_KIND_VOLT;
          end
        end
        gauge_pkg::SEQ_VOLT, gauge_pkg::SEQ_CURR:
        begin
          if (!measure_on)
          begin
            seq <= gauge_pkg::SEQ_IDLE;
          end
          else if (conv_evt)
          begin
            seq          <= (seq == gauge_pkg::SEQ_VOLT) ? gauge_pkg::SEQ_CURR : gauge_pkg::SEQ_TEMP;
            o_conv_start <= 1'b1;
            o_conv_kind  <= (seq == gauge_pkg::SEQ_VOLT) ? `GAUGE_KIND_CURR : `GAUGE_KIND_TEMP;
          end
        end
        gauge_pkg::SEQ_TEMP:
        begin
          if (!measure_on)
          begin
            seq <= gauge_pkg::SEQ_IDLE;
          end
          else if (seq_end)
          begin
            seq       <= (run_mode == `GAUGE_MODE_SCAN) ? gauge_pkg::SEQ_PAUSE : gauge_pkg::SEQ_IDLE;
            pause_cnt <= 32'(SCAN_WAIT_CYCLES);
          end
        end
        gauge_pkg::SEQ_PAUSE:
        begin
          if ((mode != `GAUGE_MODE_SCAN) || (pause_cnt <= 32'h0000_0001))
          begin
            seq <= gauge_pkg::SEQ_IDLE;
          end
          pause_cnt <= pause_cnt - 32'h0000_0001;
        end
        default:
        begin
          seq <= gauge_pkg::SEQ_IDLE;
        end
      endcase
    end
  end
endmodule : gauge_status_control_regs

// File: design/gauge_consts.svh
// Offsets, field positions, reset values, encodings and timing counts of the gauge register logic.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef GAUGE_CONSTS_SVH
`define GAUGE_CONSTS_SVH

// Register selection on the serial-side request port.
`define GAUGE_SEL_STATUS    1'h0
`define GAUGE_SEL_CONTROL   1'h1

// Serial-side operations.
`define GAUGE_OP_READ       2'h0
`define GAUGE_OP_WRITE      2'h1
`define GAUGE_OP_ALERT_ACK  2'h2

// Status register bit positions.
`define GAUGE_ST_RSVD       7
`define GAUGE_ST_CURR       6
`define GAUGE_ST_WRAP       5
`define GAUGE_ST_TEMP       4
`define GAUGE_ST_CHG_HI     3
`define GAUGE_ST_CHG_LO     2
`define GAUGE_ST_VOLT       1
`define GAUGE_ST_DROP       0

// Control register field positions.
`define GAUGE_CT_MODE_MSB   7
`define GAUGE_CT_MODE_LSB   6
`define GAUGE_CT_PRE_MSB    5
`define GAUGE_CT_PRE_LSB    3
`define GAUGE_CT_PIN_MSB    2
`define GAUGE_CT_PIN_LSB    1
`define GAUGE_CT_SHDN       0

// Reset values.
`define GAUGE_STATUS_RST    8'h01
`define GAUGE_CONTROL_RST   8'h3c

// Conversion modes.
`define GAUGE_MODE_SLEEP    2'h0
`define GAUGE_MODE_SINGLE   2'h1
`define GAUGE_MODE_SCAN     2'h2
`define GAUGE_MODE_AUTO     2'h3

// Multifunction pin functions.
`define GAUGE_PIN_OFF       2'h0
`define GAUGE_PIN_CHG_DONE  2'h1
`define GAUGE_PIN_ALERT     2'h2

// Conversion kinds.
`define GAUGE_KIND_VOLT     2'h0
`define GAUGE_KIND_CURR     2'h1
`define GAUGE_KIND_TEMP     2'h2

// Prescaler codes at or above this value all give the largest divisor.
`define GAUGE_PRE_CAP_CODE  3'h6
`define GAUGE_PRE_CAP_SHIFT 4'hc

// Scan-mode pause and the clock rate it is counted in.
`define GAUGE_SCAN_PAUSE_MS 10000
`define GAUGE_MCLK_KHZ      100000
`define GAUGE_SCAN_CYCLES   (`GAUGE_SCAN_PAUSE_MS * `GAUGE_MCLK_KHZ)

`endif

// File: design/gauge_pkg.sv
// Types shared by the gauge register logic.
// Assumes nothing beyond the constants header.
package gauge_pkg;
  `include "gauge_consts.svh"

  // Conversion sequencer states.
  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_VOLT,
    SEQ_CURR,
    SEQ_TEMP,
    SEQ_PAUSE
  } seq_state_e;

  typedef logic [7:0] reg_byte_t;
endpackage : gauge_pkg

// File: design/gauge_sync2.sv
// Two-stage synchroniser for levels and toggles entering a clock domain.
// Assumes each bit changes independently or is a toggle.
module gauge_sync2 #(
  parameter int WIDTH = 1
) (
  // Destination clock.
  input  wire logic             i_clk,
  // Asynchronous level in, synchronised level out.
  input  wire logic [WIDTH-1:0] i_d,
  output logic      [WIDTH-1:0] o_q
);
  logic [WIDTH-1:0] meta;

  // The first stage feeds only the second stage.
  always_ff @(posedge i_clk)
  begin
    meta <= i_d;
    o_q  <= meta;
  end
endmodule : gauge_sync2

// File: tb/gauge_regs_properties.sv
// Port-level checks of the gauge register logic, bound into each instance.
// Assumes an unrelated link clock and a reset synchronous to the core clock.
`include "gauge_consts.svh"
module gauge_regs_properties #(
  parameter int ACR_WIDTH = 16
) (
  // Clocks and reset.
  input wire logic                 i_mclk,
  input wire logic                 i_srst,
  input wire logic                 i_lclk,
  // Link answers.
  input wire logic                 o_lnk_busy,
  input wire logic                 o_lnk_done,
  input wire logic [7:0]           o_lnk_rdata,
  // Measurement side.
  input wire logic                 i_conv_done,
  input wire logic                 o_conv_start,
  input wire logic [1:0]           o_conv_kind,
  input wire logic                 i_int_up,
  input wire logic                 i_int_down,
  input wire logic [ACR_WIDTH-1:0] o_accumulated_charge_count,
  input wire logic                 i_supply_low,
  input wire logic                 o_analog_on,
  // Multifunction pin.
  input wire logic                 i_alert_charge_done_pin,
  input wire logic                 o_alert_charge_done_pin,
  input wire logic                 o_alert_charge_done_pin_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_srst);

  // Short names for the count and for events that may raise an alert flag.
  wire logic [ACR_WIDTH-1:0] accumulated_charge_count   = o_accumulated_charge_count;
  wire logic                 cause = i_conv_done || i_int_up || i_int_down;

  // A conversion of kind k ends one cycle after its start; the next kind must start at once.
  sequence s_done(k);
    o_analog_on && i_conv_done && $past(o_conv_start) && o_conv_kind == k;
  endsequence
  property p_next(k, nk);
    s_done(k) |=> o_conv_start && o_conv_kind == nk;
  endproperty

  a_volt_then_curr: assert property (p_next(`GAUGE_KIND_VOLT, `GAUGE_KIND_CURR))
    else $error("current conversion did not follow voltage");
  a_curr_then_temp: assert property (p_next(`GAUGE_KIND_CURR, `GAUGE_KIND_TEMP))
    else $error("temperature conversion did not follow current");
  a_start_one_cycle: assert property (o_conv_start |=> !o_conv_start)
    else $error("conversion start wider than one cycle");
  a_count_steps_one: assert property ($changed(accumulated_charge_count) |->
    accumulated_charge_count == $past(accumulated_charge_count) + 1'b1 || accumulated_charge_count == $past(accumulated_charge_count) - 1'b1 || &accumulated_charge_count)
    else $error("charge count moved by more than one step");
  a_dropout_holds: assert property ((i_supply_low && i_alert_charge_done_pin)[*5] |-> $stable(accumulated_charge_count))
    else $error("charge count moved during supply dropout");
  a_shutdown_holds: assert property ((!o_analog_on && i_alert_charge_done_pin)[*5] |-> $stable(accumulated_charge_count))
    else $error("charge count moved during shutdown");
  a_alert_has_cause: assert property ($rose(o_alert_charge_done_pin_oe) |-> $past(cause))
    else $error("alert pin pulled low without a measurement event");
  a_pin_only_low: assert property (o_alert_charge_done_pin == 1'b0)
    else $error("alert pin driven high");
  a_done_one_cycle: assert property (@(posedge i_lclk) disable iff (i_srst) o_lnk_done |=> !o_lnk_done)
    else $error("link done wider than one cycle");
  a_busy_then_done: assert property (@(posedge i_lclk) disable iff (i_srst)
    $rose(o_lnk_busy) |-> ##[2:12] o_lnk_done)
    else $error("link request not answered in time");
  a_rdata_with_done: assert property (@(posedge i_lclk) disable iff (i_srst)
    $changed(o_lnk_rdata) |-> o_lnk_done)
    else $error("read data changed without a done pulse");
endmodule : gauge_regs_properties

bind gauge_status_control_regs gauge_regs_properties #(.ACR_WIDTH(ACR_WIDTH)) i_gauge_regs_properties (
  .i_mclk, .i_srst, .i_lclk, .o_lnk_busy, .o_lnk_done, .o_lnk_rdata, .i_conv_done, .o_conv_start,
  .o_conv_kind, .i_int_up, .i_int_down, .o_accumulated_charge_count, .i_supply_low, .o_analog_on,
  .i_alert_charge_done_pin, .o_alert_charge_done_pin, .o_alert_charge_done_pin_oe);

// File: tb/gauge_host_model.sv
// Behavioural host on the register link, issuing one request at a time.
// Assumes a request is taken at a link edge while idle and answered by a done pulse.
`include "gauge_consts.svh"
module gauge_host_model (
  // Link clock.
  input  wire logic       i_lclk,
  // Requests towards the gauge.
  output logic            o_read,
  output logic            o_write,
  output logic            o_ack,
  output logic            o_sel,
  output logic [7:0]      o_wdata,
  // Answers from the gauge.
  input  wire logic       i_busy,
  input  wire logic       i_done,
  input  wire logic [7:0] i_rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // Request lines start idle.
  initial
  begin
    o_read  = 1'b0;
    o_write = 1'b0;
    o_ack   = 1'b0;
    o_sel   = 1'b0;
    o_wdata = 8'ha5;
  end

  // Holds a request over the taking edge, then waits a bounded time for the done pulse.
  task automatic op(input logic [1:0] k, input logic s, input logic [7:0] wd, output logic [7:0] rd,
                    output logic ok);
    int n;
    if (k == `GAUGE_OP_WRITE && wd[2:1] == 2'h3)
      wd[2:1] = `GAUGE_PIN_OFF;
    ok = 1'b0;
    rd = 8'h00;
    @(negedge i_lclk);
    o_sel   = s;
    o_wdata = wd;
    o_read  = (k == `GAUGE_OP_READ);
    o_write = (k == `GAUGE_OP_WRITE);
    o_ack   = (k == `GAUGE_OP_ALERT_ACK);
    @(negedge i_lclk);
    o_read  = 1'b0;
    o_write = 1'b0;
    o_ack   = 1'b0;
    o_wdata = ~wd;
    for (n = 0; n < 20 && !ok; n++)
    begin
      @(negedge i_lclk);
      if (i_done === 1'b1)
      begin
        ok = 1'b1;
        rd = i_rdata;
      end
    end
  endtask : op
endmodule : gauge_host_model

// File: tb/testbench.sv
// Self-checking bench of the gauge register logic: host requests, measurement stimulus, expectations.
// Assumes the host model and the bound checker are compiled first.
`include "gauge_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  // Design-side signals, named after the ports they reach.
  logic        i_mclk = 1'b0;
  logic        i_lclk = 1'b0;
  logic        i_srst = 1'b1;
  wire logic   i_lnk_read, i_lnk_write, i_lnk_alert_ack, i_lnk_sel;
  wire logic [7:0] i_lnk_wdata;
  logic        o_lnk_busy, o_lnk_done, o_conv_start, o_analog_on;
  logic [7:0]  o_lnk_rdata, v;
  logic        i_conv_done = 1'b0;
  logic        conv_wait = 1'b0;
  logic [15:0] i_conv_result = 16'h0000;
  logic [15:0] i_conv_hi_limit = 16'h8000;
  logic [15:0] i_conv_lo_limit = 16'h1000;
  logic [1:0]  o_conv_kind;
  logic        i_int_up = 1'b0;
  logic        i_int_down = 1'b0;
  logic [15:0] i_chg_hi_limit = 16'hfffe;
  logic [15:0] i_chg_lo_limit = 16'h0000;
  logic [15:0] o_accumulated_charge_count;
  logic        i_supply_low = 1'b0;
  logic        ext_pin = 1'b1;
  logic        o_alert_charge_done_pin, o_alert_charge_done_pin_oe;
  int          n_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
  // Open-drain pin: pulled up unless someone pulls it low.
  wire logic   i_alert_charge_done_pin = o_alert_charge_done_pin_oe ? o_alert_charge_done_pin : ext_pin;

  // Core clock and an unrelated link clock.
  initial
  begin
    forever #5 i_mclk = ~i_mclk;
  end
  initial
  begin
    #13;
    forever #40 i_lclk = ~i_lclk;
  end

  gauge_status_control_regs #(.ACR_WIDTH(16), .SCAN_WAIT_CYCLES(20)) i_gauge_status_control_regs (
    .i_mclk, .i_srst, .i_lclk, .i_lnk_read, .i_lnk_write, .i_lnk_alert_ack, .i_lnk_sel, .i_lnk_wdata,
    .o_lnk_busy, .o_lnk_done, .o_lnk_rdata, .i_conv_done, .i_conv_result, .i_conv_hi_limit,
    .i_conv_lo_limit, .o_conv_start, .o_conv_kind, .i_int_up, .i_int_down, .i_chg_hi_limit,
    .i_chg_lo_limit, .o_accumulated_charge_count, .i_supply_low, .o_analog_on,
    .i_alert_charge_done_pin, .o_alert_charge_done_pin, .o_alert_charge_done_pin_oe);
  gauge_host_model i_gauge_host_model (
    .i_lclk, .o_read(i_lnk_read), .o_write(i_lnk_write), .o_ack(i_lnk_alert_ack), .o_sel(i_lnk_sel),
    .o_wdata(i_lnk_wdata), .i_busy(o_lnk_busy), .i_done(o_lnk_done), .i_rdata(o_lnk_rdata));

  // Measurement section: each conversion answers two cycles after its start, so starts stay one-cycle pulses.
  // Voltage lands over, current inside and temperature under the limits.
  always @(negedge i_mclk)
  begin
    conv_wait     <= o_conv_start;
    i_conv_done   <= conv_wait;
    i_conv_result <= (o_conv_kind == `GAUGE_KIND_VOLT) ? 16'h9000 :
                     (o_conv_kind == `GAUGE_KIND_CURR) ? 16'h4000 : 16'h0800;
  end

  // Cuts a hang short.
  always @(posedge i_mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_errors++;
      end_sim();
    end
  end

  task automatic end_sim;
    if (n_errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim

  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp

  task automatic host(input logic [1:0] k, input logic s, input logic [7:0] d, output logic [7:0] r);
    logic ok;
    i_gauge_host_model.op(k, s, d, r, ok);
    cmp({15'h0, ok}, 16'h0001);
  endtask : host

  task automatic rd(input logic s, input logic [7:0] e);
    logic [7:0] r;
    host(`GAUGE_OP_READ, s, 8'h00, r);
    cmp({8'h00, r}, {8'h00, e});
  endtask : rd

  task automatic wr(input logic s, input logic [7:0] d);
    logic [7:0] r;
    host(`GAUGE_OP_WRITE, s, d, r);
  endtask : wr

  task automatic idle(input int n);
    repeat (n) @(negedge i_mclk);
  endtask : idle

  // Integrator steps, one cycle wide, then time for the count to settle.
  task automatic tick(input logic up, input int n);
    repeat (n)
    begin
      @(negedge i_mclk);
      i_int_up   = up;
      i_int_down = !up;
      @(negedge i_mclk);
      i_int_up   = 1'b0;
      i_int_down = 1'b0;
    end
    idle(3);
  endtask : tick

  // Main sequence.
  initial
  begin
    idle(40);
    i_srst = 1'b0;
    repeat (4) @(negedge i_lclk);
    cmp({15'h0, o_analog_on}, 16'h0001);
    rd(1'h0, 8'h01);
    rd(1'h0, 8'h00);
    rd(1'h1, 8'h3c);
    wr(1'h0, 8'hff);
    rd(1'h0, 8'h00);
    wr(1'h1, 8'h44);
    idle(20);
    rd(1'h1, 8'h04);
    rd(1'h0, 8'h12);
    wr(1'h1, 8'h00);
    idle(10);
    cmp({15'h0, o_alert_charge_done_pin_oe}, 16'h0001);
    host(`GAUGE_OP_ALERT_ACK, 1'h0, 8'h00, v);
    idle(10);
    cmp({15'h0, o_alert_charge_done_pin_oe}, 16'h0000);
    tick(1'b0, 1);
    cmp(o_accumulated_charge_count, 16'hffff);
    rd(1'h0, 8'h28);
    tick(1'b1, 1);
    cmp(o_accumulated_charge_count, 16'h0000);
    rd(1'h0, 8'h20);
    i_chg_lo_limit = 16'h0005;
    tick(1'b1, 2);
    rd(1'h0, 8'h04);
    wr(1'h1, 8'h08);
    tick(1'b1, 3);
    cmp(o_accumulated_charge_count, 16'h0002);
    tick(1'b1, 3);
    cmp(o_accumulated_charge_count, 16'h0003);
    wr(1'h1, 8'h09);
    idle(4);
    cmp({15'h0, o_analog_on}, 16'h0000);
    tick(1'b1, 8);
    cmp(o_accumulated_charge_count, 16'h0003);
    rd(1'h1, 8'h09);
    wr(1'h1, 8'h08);
    tick(1'b1, 3);
    cmp(o_accumulated_charge_count, 16'h0003);
    tick(1'b1, 1);
    cmp(o_accumulated_charge_count, 16'h0004);
    i_supply_low = 1'b1;
    idle(6);
    tick(1'b1, 8);
    cmp(o_accumulated_charge_count, 16'h0004);
    rd(1'h0, 8'h05);
    rd(1'h0, 8'h01);
    i_supply_low = 1'b0;
    idle(6);
    tick(1'b1, 4);
    cmp(o_accumulated_charge_count, 16'h0005);
    cmp({15'h0, o_alert_charge_done_pin_oe}, 16'h0000);
    // Scan mode repeats the sequence, auto runs it back to back, sleep stops it after the running one.
    wr(1'h1, 8'h88);
    idle(40);
    rd(1'h0, 8'h17);
    idle(40);
    rd(1'h0, 8'h12);
    wr(1'h1, 8'hc8);
    idle(10);
    rd(1'h0, 8'h12);
    wr(1'h1, 8'h08);
    rd(1'h0, 8'h12);
    idle(20);
    rd(1'h0, 8'h00);
    wr(1'h1, 8'h0a);
    ext_pin = 1'b0;
    idle(6);
    cmp(o_accumulated_charge_count, 16'hffff);
    cmp({15'h0, o_alert_charge_done_pin_oe}, 16'h0000);
    ext_pin = 1'b1;
    end_sim();
  end
endmodule : testbench
